// file: rtl/power_mgmt_pkg.sv
// power management register set: offsets, field positions, reset values
// assumes an 8-bit special function register access port on the core clock
package power_mgmt_pkg;

  // register addresses on the special function register port
  localparam logic [7:0] ADDR_KEY_UNLOCK   = 8'h00_C1;
  localparam logic [7:0] ADDR_IRQ_PIN_CFG  = 8'h00_FF;
  localparam logic [7:0] ADDR_PERIPHERAL_CONFIG_REGISTER_CFG   = 8'h00_F4;
  localparam logic [7:0] ADDR_SWITCHOVER   = 8'h00_F5;
  localparam logic [7:0] ADDR_EVENT_FLAGS  = 8'h00_F8;
  localparam logic [7:0] ADDR_EVENT_ENABLE = 8'h00_EC;
  localparam logic [7:0] ADDR_CONV_START   = 8'h00_D8;

  // bit addresses of the flag register bits (bit-addressable window)
  localparam logic [7:0] BITADDR_FLAGS_BASE = 8'h00_F8;
  localparam logic [7:0] BITADDR_FLAGS_TOP  = 8'h00_FF;

  // unlock value for the interrupt-pin configuration register
  localparam logic [7:0] KEY_IRQ_PIN_UNLOCK = 8'h00_EA;

  // power event flag bit positions
  localparam int FLAG_SUPPLY_RESTORED = 7;
  localparam int FLAG_POWER_SUMMARY   = 6;
  localparam int FLAG_LINE_SAG        = 5;
  localparam int FLAG_RESERVED        = 4;
  localparam int FLAG_DC_INPUT_ADC    = 3;
  localparam int FLAG_BATTERY_MONITOR = 2;
  localparam int FLAG_SWITCHOVER      = 1;
  localparam int FLAG_DC_INPUT_LOW    = 0;

  // peripheral configuration bit positions
  localparam int PERIPHERAL_CONFIG_REGISTER_RX_WAKE   = 7;
  localparam int PERIPHERAL_CONFIG_REGISTER_SOURCE    = 6;
  localparam int PERIPHERAL_CONFIG_REGISTER_MAIN_OK   = 5;
  localparam int PERIPHERAL_CONFIG_REGISTER_PLL_FAULT = 4;
  localparam int PERIPHERAL_CONFIG_REGISTER_REF_SLEEP = 3;
  localparam int CONV_PLL_ACK     = 7;

  // writable masks: reserved bits stay zero
  localparam logic [7:0] FLAGS_WR_MASK   = 8'h00_EF;
  localparam logic [7:0] ENABLE_WR_MASK  = 8'h00_BF;
  localparam logic [7:0] SWITCH_WR_MASK  = 8'h00_03;
  localparam logic [7:0] IRQPIN_WR_MASK  = 8'h00_6F;

  // reset values
  localparam logic [7:0] RESET_FLAGS     = 8'h00_00;
  localparam logic [7:0] RESET_ENABLE    = 8'h00_00;
  localparam logic [7:0] RESET_SWITCHOVER = 8'h00_00;
  localparam logic [7:0] RESET_IRQ_PIN   = 8'h00_00;
  localparam logic [7:0] RESET_KEY       = 8'h00_00;
  localparam logic [1:0] RESET_RX_FUNC   = 2'h0;

  // switchover select encodings
  typedef enum logic [1:0] {
    SW_LOW_MAIN        = 2'b00,
    SW_LOW_MAIN_OR_DC  = 2'b01,
    SW_DISABLED_A      = 2'b10,
    SW_DISABLED_B      = 2'b11
  } switchover_select_e;

  // receive pin function encodings
  typedef enum logic [1:0] {
    RX_GPIO        = 2'b00,
    RX_NO_WAKE     = 2'b01,
    RX_RESERVED    = 2'b10,
    RX_WITH_WAKE   = 2'b11
  } rx_pin_function_e;

endpackage

// file: rtl/power_mgmt_status_regs.sv
// power management register set: key lock, event flags, switchover and
// peripheral configuration/status, on the core's special function port
// assumes one clock; analog status pins arrive asynchronously and are
// synchronised here; event pulses from on-chip logic are same-clock
//
// Behaviour
// - pin configuration writes allowed only while key register holds 0xEA
// - supply-restored flag, bit 7, sets on battery to main change
// - summary flag, bit 6, sets on any enabled power event
// - line sag flag, bit 5, sets on front-end sag report
// - dc input converter flag, bit 3, sets on delta or new measurement
// - battery monitor flag, bit 2, sets on low battery or new measurement
// - switchover flag, bit 1, sets on main to battery change
// - dc input low flag, bit 0, sets when dc input under 1.2 V
// - switchover select: 00 low main, 01 main or dc low, 1X disabled
// - peripheral bit 7 sets when receive edge woke deep sleep
// - peripheral bit 6 shows supply source, 1 main, resets to 1
// - peripheral bit 5 shows main supply ready, resets to 1
// - pll fault bit 4 sets on lost lock, cleared by ack write
// - peripheral bit 3 keeps reference enabled in deep sleep
// - receive pin function: 00 gpio, 01 rx no wake, 11 rx wake
// - each flag feeds summary only when its enable bit is set
module power_mgmt_status_regs
  import power_mgmt_pkg::*;
(
  input  wire logic       clock_i,
  input  wire logic       resetn_i,
  input  wire logic       clock_en_i,
  // special function register port
  input  wire logic [7:0] sfr_addr_i,
  input  wire logic [7:0] sfr_wdata_i,
  input  wire logic       sfr_wr_i,
  input  wire logic       sfr_rd_i,
  input  wire logic [7:0] bit_addr_i,
  input  wire logic       bit_wdata_i,
  input  wire logic       bit_wr_i,
  output logic      [7:0] sfr_rdata_o,
  output logic            sfr_rvalid_o,
  // analog status levels (asynchronous)
  input  wire logic       main_supply_low_i,
  input  wire logic       dc_input_low_i,
  input  wire logic       main_supply_ok_i,
  input  wire logic       pll_locked_i,
  input  wire logic       second_rx_input_i,
  // same-clock event pulses
  input  wire logic       line_sag_i,
  input  wire logic       dc_input_delta_i,
  input  wire logic       dc_input_meas_done_i,
  input  wire logic       battery_low_i,
  input  wire logic       battery_meas_done_i,
  input  wire logic       deep_sleep_mode_i,
  // controls out
  output logic            switched_supply_out_o,
  output logic            power_summary_irq_o,
  output logic            ref_in_sleep_enable_o,
  output logic      [1:0] rx_pin_function_o,
  output logic      [7:0] irq_pin_config_o
);

  typedef struct packed {
    logic [2:0] sync_main_low;
    logic [2:0] sync_dc_low;
    logic [2:0] sync_main_ok;
    logic [2:0] sync_pll_lock;
    logic [2:0] sync_rx;
    logic       main_low;     // filtered levels
    logic       dc_low;
    logic       main_ok;
    logic       pll_lock;
    logic       rx_level;
    logic       on_battery;   // 1 while switched supply is from battery
    logic [7:0] key;
    logic [7:0] irq_pin;
    logic [7:0] flags;
    logic [7:0] enable;
    logic [1:0] sw_select;
    logic       rx_wake;
    logic       pll_fault;
    logic       ref_sleep;
    logic [1:0] rx_func;
    logic [7:0] rdata;
    logic       rvalid;
  } state_s;

  state_s cur;
  state_s next_cur;

  // address match used by byte writes; reads decode the address with a case
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ref_addr);
    hit = (a == ref_addr);
  endfunction

  // filtered level: change accepted once stages two and three agree
  function automatic logic filt(input logic [2:0] s, input logic prev);
    filt = (s[1] == s[2]) ? s[2] : prev;
  endfunction

  logic       wr_flags;
  logic       wr_enable;
  logic       wr_switch;
  logic       wr_peripheral_config_register;
  logic       wr_irqpin;
  logic [7:0] flag_set;
  logic       want_battery;
  logic [7:0] peripheral_config_register_view;

  always_comb
  begin
    wr_flags  = sfr_wr_i && hit(sfr_addr_i, ADDR_EVENT_FLAGS);
    wr_enable = sfr_wr_i && hit(sfr_addr_i, ADDR_EVENT_ENABLE);
    wr_switch = sfr_wr_i && hit(sfr_addr_i, ADDR_SWITCHOVER);
    wr_peripheral_config_register = sfr_wr_i && hit(sfr_addr_i, ADDR_PERIPHERAL_CONFIG_REGISTER_CFG);
    wr_irqpin = sfr_wr_i && hit(sfr_addr_i, ADDR_IRQ_PIN_CFG);
  end

  // switchover decision; 1X never moves to battery, so it also returns
  always_comb
  begin
    case (switchover_select_e'(cur.sw_select))
      SW_LOW_MAIN:       want_battery = cur.main_low;
      SW_LOW_MAIN_OR_DC: want_battery = cur.main_low | cur.dc_low;
      default:           want_battery = 1'b0;
    endcase
  end

  // event set terms; summary built from the enabled individual events
  always_comb
  begin
    flag_set = 8'h00_00;
    flag_set[FLAG_SUPPLY_RESTORED] = cur.on_battery & ~want_battery;
    flag_set[FLAG_LINE_SAG]        = line_sag_i;
    flag_set[FLAG_DC_INPUT_ADC]    = dc_input_delta_i | dc_input_meas_done_i;
    flag_set[FLAG_BATTERY_MONITOR] = battery_low_i | battery_meas_done_i;
    flag_set[FLAG_SWITCHOVER]      = ~cur.on_battery & want_battery;
    // rising edge of the filtered level, seen as it is accepted
    flag_set[FLAG_DC_INPUT_LOW]    = filt(cur.sync_dc_low, cur.dc_low) & ~cur.dc_low;
    flag_set[FLAG_POWER_SUMMARY]   = |(flag_set & cur.enable & ENABLE_WR_MASK);
  end

  // peripheral register as software reads it
  always_comb
  begin
    peripheral_config_register_view = {cur.rx_wake, ~cur.on_battery, cur.main_ok, cur.pll_fault,
                   cur.ref_sleep, 1'b0, cur.rx_func};
  end

  // next-state logic; hardware sets beat software clears in the same cycle
  always_comb
  begin
    next_cur = cur;
    next_cur.sync_main_low = {cur.sync_main_low[1:0], main_supply_low_i};
    next_cur.sync_dc_low   = {cur.sync_dc_low[1:0], dc_input_low_i};
    next_cur.sync_main_ok  = {cur.sync_main_ok[1:0], main_supply_ok_i};
    next_cur.sync_pll_lock = {cur.sync_pll_lock[1:0], pll_locked_i};
    next_cur.sync_rx       = {cur.sync_rx[1:0], second_rx_input_i};
    next_cur.main_low = filt(cur.sync_main_low, cur.main_low);
    next_cur.dc_low   = filt(cur.sync_dc_low, cur.dc_low);
    next_cur.main_ok  = filt(cur.sync_main_ok, cur.main_ok);
    next_cur.pll_lock = filt(cur.sync_pll_lock, cur.pll_lock);
    next_cur.rx_level = filt(cur.sync_rx, cur.rx_level);
    next_cur.on_battery = want_battery;

    // key register at its own address; software closes it again
    if (sfr_wr_i && hit(sfr_addr_i, ADDR_KEY_UNLOCK))
      next_cur.key = sfr_wdata_i;

    // protected register: ignored unless unlocked
    if (wr_irqpin && (cur.key == KEY_IRQ_PIN_UNLOCK))
      next_cur.irq_pin = sfr_wdata_i & IRQPIN_WR_MASK;

    if (wr_enable)
      next_cur.enable = sfr_wdata_i & ENABLE_WR_MASK;
    if (wr_switch)
      next_cur.sw_select = sfr_wdata_i[1:0];
    if (wr_peripheral_config_register)
    begin
      next_cur.ref_sleep = sfr_wdata_i[PERIPHERAL_CONFIG_REGISTER_REF_SLEEP];
      next_cur.rx_func   = sfr_wdata_i[1:0];
      next_cur.rx_wake   = cur.rx_wake & sfr_wdata_i[PERIPHERAL_CONFIG_REGISTER_RX_WAKE];
    end

    // flag register: byte write, then single-bit write, then sets
    if (wr_flags)
      next_cur.flags = sfr_wdata_i & FLAGS_WR_MASK;
    if (bit_wr_i && (bit_addr_i >= BITADDR_FLAGS_BASE)
        && (bit_addr_i != (BITADDR_FLAGS_BASE + 8'h00_04)))
      next_cur.flags[bit_addr_i[2:0]] = bit_wdata_i;
    next_cur.flags = next_cur.flags | flag_set;

    // wake flag only when the pin is a receive input with wake-up
    if (deep_sleep_mode_i && (rx_pin_function_e'(cur.rx_func) == RX_WITH_WAKE)
        && (cur.rx_level != filt(cur.sync_rx, cur.rx_level)))
      next_cur.rx_wake = 1'b1;

    // pll fault: ack write clears, loss of lock sets and wins
    if (sfr_wr_i && hit(sfr_addr_i, ADDR_CONV_START) && sfr_wdata_i[CONV_PLL_ACK])
      next_cur.pll_fault = 1'b0;
    if (!cur.pll_lock)
      next_cur.pll_fault = 1'b1;

    // read port, one cycle latency; unmapped reads return zero
    next_cur.rvalid = sfr_rd_i;
    next_cur.rdata  = 8'h00_00;
    if (sfr_rd_i)
    begin
      case (sfr_addr_i)
        ADDR_KEY_UNLOCK:   next_cur.rdata = cur.key;
        ADDR_IRQ_PIN_CFG:  next_cur.rdata = cur.irq_pin;
        ADDR_EVENT_FLAGS:  next_cur.rdata = cur.flags;
        ADDR_EVENT_ENABLE: next_cur.rdata = cur.enable;
        ADDR_SWITCHOVER:   next_cur.rdata = {6'h00, cur.sw_select};
        ADDR_PERIPHERAL_CONFIG_REGISTER_CFG:   next_cur.rdata = peripheral_config_register_view;
        default:           next_cur.rdata = 8'h00_00;
      endcase
    end
  end

  // single register of the whole state; clock enable freezes it all
  always_ff @(posedge clock_i)
  begin
    if (!resetn_i)
    begin
      cur            <= '0;
      cur.main_ok    <= 1'b1;
      cur.pll_lock   <= 1'b1;   // avoid a false fault before first sample
      // sync stages start at the good level so the filter does not drop them
      cur.sync_main_ok  <= 3'h7;
      cur.sync_pll_lock <= 3'h7;
      cur.on_battery <= 1'b0;
      cur.key        <= RESET_KEY;
      cur.irq_pin    <= RESET_IRQ_PIN;
      cur.flags      <= RESET_FLAGS;
      cur.enable     <= RESET_ENABLE;
      cur.sw_select  <= RESET_SWITCHOVER[1:0];
      cur.rx_func    <= RESET_RX_FUNC;
    end
    else if (clock_en_i)
      cur <= next_cur;
  end

  // outputs straight from state flip-flops
  assign sfr_rdata_o           = cur.rdata;
  assign sfr_rvalid_o          = cur.rvalid;
  assign switched_supply_out_o = ~cur.on_battery;
  assign power_summary_irq_o   = cur.flags[FLAG_POWER_SUMMARY];
  assign ref_in_sleep_enable_o = cur.ref_sleep;
  assign rx_pin_function_o     = cur.rx_func;
  assign irq_pin_config_o      = cur.irq_pin;

endmodule

// file: testbench/power_mgmt_properties.sv
// port-level checks for the power management register set
// assumes the package constants and one core clock domain
module power_mgmt_checker
  import power_mgmt_pkg::*;
(
  input wire logic       clock_i,
  input wire logic       resetn_i,
  input wire logic       clock_en_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic       sfr_wr_i,
  input wire logic       sfr_rd_i,
  input wire logic [7:0] sfr_rdata_o,
  input wire logic       sfr_rvalid_o,
  input wire logic       switched_supply_out_o,
  input wire logic       power_summary_irq_o,
  input wire logic       ref_in_sleep_enable_o,
  input wire logic [1:0] rx_pin_function_o,
  input wire logic [7:0] irq_pin_config_o
);
  logic [7:0] key_q;
  logic [3:0] dis_cnt;
  logic       wr_ok;
  logic       rd_ok;
  assign wr_ok = clock_en_i && sfr_wr_i;
  assign rd_ok = clock_en_i && sfr_rd_i;
  // key shadow; count saturates so long disabled spans stay cheap
  always_ff @(posedge clock_i)
  begin
    if (!resetn_i)
    begin
      key_q   <= '0;
      dis_cnt <= '0;
    end
    else if (wr_ok && sfr_addr_i == ADDR_KEY_UNLOCK)
      key_q <= sfr_wdata_i;
    else if (wr_ok && sfr_addr_i == ADDR_SWITCHOVER)
      dis_cnt <= {3'h0, sfr_wdata_i[1]};
    else if (dis_cnt != 4'h0 && dis_cnt != 4'hF)
      dis_cnt <= dis_cnt + 4'h1;
  end
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!resetn_i);
  chk_key_lock: assert property ($past(resetn_i) && $changed(irq_pin_config_o) |->
    $past(wr_ok && sfr_addr_i == ADDR_IRQ_PIN_CFG && key_q == KEY_IRQ_PIN_UNLOCK))
    else $error("pin config changed without key");
  chk_key_write: assert property (wr_ok && sfr_addr_i == ADDR_IRQ_PIN_CFG &&
    key_q == KEY_IRQ_PIN_UNLOCK |=> irq_pin_config_o == ($past(sfr_wdata_i) & IRQPIN_WR_MASK))
    else $error("unlocked pin config write lost");
  chk_peripheral_config_register_read: assert property (rd_ok && sfr_addr_i == ADDR_PERIPHERAL_CONFIG_REGISTER_CFG |=>
    sfr_rdata_o[6] == $past(switched_supply_out_o) && !sfr_rdata_o[2] &&
    sfr_rdata_o[3] == $past(ref_in_sleep_enable_o) && sfr_rdata_o[1:0] == $past(rx_pin_function_o))
    else $error("peripheral read differs from outputs");
  chk_summary_read: assert property (rd_ok && sfr_addr_i == ADDR_EVENT_FLAGS |=>
    sfr_rdata_o[6] == $past(power_summary_irq_o) && !sfr_rdata_o[4])
    else $error("flag read differs from summary");
  chk_switch_off: assert property (dis_cnt > 4'h8 |-> !$fell(switched_supply_out_o))
    else $error("switched to battery while disabled");
  chk_read_answer: assert property (clock_en_i |=> sfr_rvalid_o == $past(sfr_rd_i) &&
    ($past(sfr_rd_i) || sfr_rdata_o == 8'h00))
    else $error("read answer timing wrong");
  chk_hold_frozen: assert property (!clock_en_i |=> $stable(irq_pin_config_o) &&
    $stable(switched_supply_out_o) && $stable(power_summary_irq_o))
    else $error("state moved while clock enable low");
  chk_reset_values: assert property ($rose(resetn_i) |-> switched_supply_out_o &&
    irq_pin_config_o == 8'h00 && !power_summary_irq_o)
    else $error("outputs wrong after reset");
endmodule

bind power_mgmt_status_regs power_mgmt_checker chk_u (.clock_i, .resetn_i, .clock_en_i,
  .sfr_addr_i, .sfr_wdata_i, .sfr_wr_i, .sfr_rd_i, .sfr_rdata_o, .sfr_rvalid_o,
  .switched_supply_out_o, .power_summary_irq_o, .ref_in_sleep_enable_o,
  .rx_pin_function_o, .irq_pin_config_o);

// file: testbench/power_mgmt_status_regs_tb.sv
// self-checking bench for the power management register set
// assumes one-cycle register port answers and 3-4 edge status sync
module power_mgmt_status_regs_tb
  import power_mgmt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clock_i = 0, resetn_i = 0, clock_en_i = 1, sfr_wr_i = 0, sfr_rd_i = 0;
  logic       bit_wdata_i = 0, bit_wr_i = 0, main_supply_low_i = 0, dc_input_low_i = 0;
  logic       main_supply_ok_i = 1, pll_locked_i = 1, second_rx_input_i = 1;
  logic       deep_sleep_mode_i = 0, sfr_rvalid_o, switched_supply_out_o;
  logic       power_summary_irq_o, ref_in_sleep_enable_o;
  logic [7:0] sfr_addr_i = '0, sfr_wdata_i = '0, bit_addr_i = '0, sfr_rdata_o, irq_pin_config_o;
  logic [1:0] rx_pin_function_o;
  logic [4:0] ev = '0;
  logic [7:0] ev_exp [5] = '{8'h20, 8'h08, 8'h08, 8'h04, 8'h04};
  logic [1:0] sel_tab [4] = '{2'h0, 2'h2, 2'h3, 2'h1};
  logic       out_tab [4] = '{1'b1, 1'b1, 1'b1, 1'b0};
  int         err_count = 0, total_checks = 0, cyc = 0;

  power_mgmt_status_regs dut_u (.clock_i, .resetn_i, .clock_en_i, .sfr_addr_i, .sfr_wdata_i,
    .sfr_wr_i, .sfr_rd_i, .bit_addr_i, .bit_wdata_i, .bit_wr_i, .sfr_rdata_o, .sfr_rvalid_o,
    .main_supply_low_i, .dc_input_low_i, .main_supply_ok_i, .pll_locked_i,
    .second_rx_input_i, .line_sag_i(ev[0]), .dc_input_delta_i(ev[1]),
    .dc_input_meas_done_i(ev[2]), .battery_low_i(ev[3]), .battery_meas_done_i(ev[4]),
    .deep_sleep_mode_i, .switched_supply_out_o, .power_summary_irq_o,
    .ref_in_sleep_enable_o, .rx_pin_function_o, .irq_pin_config_o);

  initial
    forever #2 clock_i = ~clock_i;

  task automatic complete_run();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // hang guard, well above the few hundred cycles the sequence needs
  always @(posedge clock_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_count++;
      complete_run();
    end
  end

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g,
                     input logic [7:0] m);
    total_checks++;
    if ((g & m) !== (e & m))
    begin
      err_count++;
      $display("ERROR %s exp %h got %h", n, e & m, g & m);
    end
  endtask

  // strobes rise after an edge and drop at the taking edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i);
    sfr_addr_i  <= a;
    sfr_wdata_i <= d;
    sfr_wr_i    <= 1;
    @(posedge clock_i);
    sfr_wr_i <= 0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m,
                    input string n);
    @(posedge clock_i);
    sfr_addr_i <= a;
    sfr_rd_i   <= 1;
    @(posedge clock_i);
    sfr_rd_i <= 0;
    #1;
    chk(n, e, sfr_rdata_o, m);
  endtask

  task automatic bw(input logic [7:0] a, input logic d);
    @(posedge clock_i);
    bit_addr_i  <= a;
    bit_wdata_i <= d;
    bit_wr_i    <= 1;
    @(posedge clock_i);
    bit_wr_i <= 0;
  endtask

  task automatic pulse(input int i);
    @(posedge clock_i);
    ev[i] <= 1;
    @(posedge clock_i);
    ev[i] <= 0;
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clock_i);
  endtask

  initial
  begin
    wt(10);
    resetn_i <= 1;
    wt(8);
    rd(ADDR_PERIPHERAL_CONFIG_REGISTER_CFG, 8'h60, 8'hFF, "peripheral_config_register");
    rd(ADDR_EVENT_FLAGS, 8'h00, 8'hFF, "flags");
    rd(ADDR_SWITCHOVER, 8'h00, 8'hFF, "switch");
    rd(8'hF0, 8'h00, 8'hFF, "unmapped");
    wr(ADDR_IRQ_PIN_CFG, 8'h6F);
    rd(ADDR_IRQ_PIN_CFG, 8'h00, 8'hFF, "locked");
    wr(ADDR_KEY_UNLOCK, KEY_IRQ_PIN_UNLOCK);
    wr(ADDR_IRQ_PIN_CFG, 8'h6F);
    chk("pin", 8'h6F, irq_pin_config_o, 8'hFF);
    wr(ADDR_KEY_UNLOCK, 8'h00);
    wr(ADDR_IRQ_PIN_CFG, 8'h00);
    rd(ADDR_IRQ_PIN_CFG, 8'h6F, 8'hFF, "relocked");
    // enables off first: the flag sets but the summary must not
    pulse(0);
    rd(ADDR_EVENT_FLAGS, 8'h20, 8'hFF, "sag");
    wr(ADDR_EVENT_ENABLE, 8'hBF);
    for (int i = 0; i < 5; i++)
    begin
      wr(ADDR_EVENT_FLAGS, 8'h00);
      pulse(i);
      rd(ADDR_EVENT_FLAGS, ev_exp[i] | 8'h40, 8'hFF, "event");
    end
    bw(8'hFA, 1'b0);
    bw(8'hFC, 1'b1);
    rd(ADDR_EVENT_FLAGS, 8'h40, 8'hFF, "bitwr");
    wr(ADDR_EVENT_FLAGS, 8'h00);
    @(posedge clock_i) dc_input_low_i <= 1;
    wt(8);
    rd(ADDR_EVENT_FLAGS, 8'h41, 8'hFF, "dclow");
    // every select code with only the dc input low
    foreach (sel_tab[i])
    begin
      wr(ADDR_SWITCHOVER, {6'h00, sel_tab[i]});
      wt(8);
      chk("source", {7'h00, out_tab[i]}, {7'h00, switched_supply_out_o}, 8'hFF);
    end
    rd(ADDR_PERIPHERAL_CONFIG_REGISTER_CFG, 8'h00, 8'h40, "onbat");
    rd(ADDR_EVENT_FLAGS, 8'h02, 8'h02, "tobat");
    @(posedge clock_i) dc_input_low_i <= 0;
    wt(8);
    rd(ADDR_EVENT_FLAGS, 8'h80, 8'h80, "restore");
    wr(ADDR_SWITCHOVER, 8'h00);
    @(posedge clock_i) main_supply_low_i <= 1;
    main_supply_ok_i <= 0;
    wt(8);
    rd(ADDR_PERIPHERAL_CONFIG_REGISTER_CFG, 8'h00, 8'h60, "mainlow");
    @(posedge clock_i) main_supply_low_i <= 0;
    main_supply_ok_i <= 1;
    clock_en_i <= 0;
    wt(3);
    clock_en_i <= 1;
    pll_locked_i <= 0;
    wt(8);
    wr(ADDR_CONV_START, 8'h80);
    rd(ADDR_PERIPHERAL_CONFIG_REGISTER_CFG, 8'h10, 8'h10, "pll");
    @(posedge clock_i) pll_locked_i <= 1;
    wt(8);
    wr(ADDR_CONV_START, 8'h80);
    rd(ADDR_PERIPHERAL_CONFIG_REGISTER_CFG, 8'h00, 8'h10, "pll_fault_ack");
    wr(ADDR_PERIPHERAL_CONFIG_REGISTER_CFG, 8'h01);
    chk("rxfn", 8'h01, {6'h00, rx_pin_function_o}, 8'hFF);
    wr(ADDR_PERIPHERAL_CONFIG_REGISTER_CFG, 8'h0B);
    chk("ref", 8'h0B, {4'h0, ref_in_sleep_enable_o, 1'b0, rx_pin_function_o}, 8'hFF);
    @(posedge clock_i) deep_sleep_mode_i <= 1;
    second_rx_input_i <= 0;
    wt(6);
    second_rx_input_i <= 1;
    wt(6);
    rd(ADDR_PERIPHERAL_CONFIG_REGISTER_CFG, 8'h8B, 8'h8F, "wake");
    wr(ADDR_PERIPHERAL_CONFIG_REGISTER_CFG, 8'h0B);
    rd(ADDR_PERIPHERAL_CONFIG_REGISTER_CFG, 8'h0B, 8'h8F, "wakeclr");
    complete_run();
  end
endmodule
